// ### src/smart_card_sync.sv
// Smart card bypass and synchronous mode logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "sc_sync_map.svh"
module smart_card_sync (
	input  wire logic                     clock,
	input  wire logic                     sys_rst,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output sc_sync_pkg::card_pins_s       intCard,
	input  wire logic                     intIoIn,
	output sc_sync_pkg::card_pins_s       extCard,
	input  wire logic                     extIoIn,
	output logic                          lengthIrq
);
	import sc_sync_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode shared by the read and write paths
	function automatic reg_e decodeReg(input logic [7:0] addr);
		case (addr)
			`SC_OFF_SEL:  decodeReg = REG_SEL;
			`SC_OFF_PROT: decodeReg = REG_PROT;
			`SC_OFF_IRQ:  decodeReg = REG_IRQ;
			`SC_OFF_IEN:  decodeReg = REG_IEN;
			`SC_OFF_ICTL: decodeReg = REG_ICTL;
			`SC_OFF_ECTL: decodeReg = REG_ECTL;
			`SC_OFF_TXC:  decodeReg = REG_TXC;
			`SC_OFF_TXD:  decodeReg = REG_TXD;
			`SC_OFF_RXC:  decodeReg = REG_RXC;
			`SC_OFF_RXD:  decodeReg = REG_RXD;
			`SC_OFF_ETU:  decodeReg = REG_ETU;
			`SC_OFF_RLEN: decodeReg = REG_RLEN;
			`SC_OFF_ICLK: decodeReg = REG_ICLK;
			`SC_OFF_ECLK: decodeReg = REG_ECLK;
			default:      decodeReg = REG_NONE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0]  selField_q;     // Interface select field
	logic        bypass_q;       // UART bypass
	logic [7:0]  prot_q;         // Protocol control register
	logic [7:0]  ien_q;          // Interrupt enables
	logic        direct_q;       // Direct I/O control mode
	card_ctl_s   ctl_q [2];      // Per interface control, 0 internal, 1 external
	logic [1:0]  sampleIo_q;     // Sampled I/O levels
	logic [7:0]  clkDiv_q [2];   // Asynchronous card clock dividers
	logic [7:0]  etuDiv_q;       // ETU divisor
	logic [7:0]  lenMax_q;       // Loaded length
	logic [7:0]  lenCnt_q;       // Falling edges counted
	logic        lenDone_q;      // Length reached flag
	logic        awHeld_q;       // Write address latched
	logic [7:0]  awAddr_q;       // Latched write address
	logic        wHeld_q;        // Write data latched
	logic [7:0]  wByte_q;        // Latched write byte
	logic        wLane0_q;       // Low byte lane enabled
	logic        lastTxRead_q;   // Previous access read transmit data
	logic [7:0]  txMem [2];      // Transmit FIFO storage
	logic        txWp_q, txRp_q; // Transmit pointers
	logic [1:0]  txCnt_q;        // Transmit fill
	logic [8:0]  rxMem [2];      // Receive FIFO storage
	logic        rxWp_q, rxRp_q; // Receive pointers
	logic [1:0]  rxCnt_q;        // Receive fill
	logic [8:0]  rxShift_q;      // Deserializer
	logic [3:0]  bitPtr_q;       // Serializer bit pointer
	logic        txModePrev_q;   // Direction seen last cycle
	logic        ioBit_q;        // Serial output level
	logic [7:0]  etuCnt_q;       // ETU counter
	logic        sclk_q;         // Synchronous clock
	logic        sclkPrev_q;     // Clock one cycle earlier
	logic        haltPrev_q;     // Halt one cycle earlier
	logic        skip_q;         // Suppress next FIFO fall
	clk_state_e  clkState_q;     // Clock engine state
	logic [7:0]  freeCnt_q [2];  // Asynchronous divider counters
	logic [1:0]  freeClk_q;      // Asynchronous clocks
	logic        doWrite, rdGo, selInt, selExt, selIdx, syncOn, etuTick;
	logic        riseEv, fallEv, haltFall, atEnd, regCtl, fifoPath, fifoFall, rxRise;
	logic [7:0]  wrByte, rdByte;
	reg_e        wrReg, rdReg;
	logic [1:0]  ioIn;
	card_pins_s  pins [2];

	////////////////////////////////////////////////////////////////////////////////
	// Decoded selection and events
	always_comb
	begin
		selInt   = selField_q[1];
		selExt   = selField_q == 2'h1;
		selIdx   = !selInt;
		syncOn   = (selInt && prot_q[`SC_PROT_ISYNC]) ||
		           (selExt && prot_q[`SC_PROT_ESYNC]);
		// At or past the divisor, so lowering it mid-phase cannot stall until a wrap
		etuTick  = etuCnt_q >= etuDiv_q;
		riseEv   = sclk_q && !sclkPrev_q;
		fallEv   = !sclk_q && sclkPrev_q;
		haltFall = haltPrev_q && !ctl_q[selIdx].halt;
		atEnd    = lenMax_q == 8'h00 || lenCnt_q == lenMax_q;
		regCtl   = bypass_q || lenMax_q == 8'h00 || (atEnd && direct_q);
		fifoPath = syncOn && !atEnd && !bypass_q;
		fifoFall = fallEv && fifoPath && ctl_q[selIdx].txMode && !skip_q;
		rxRise   = riseEv && fifoPath && !ctl_q[selIdx].txMode;
		ioIn     = {extIoIn, intIoIn};
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign rdGo          = s_axi_arvalid && s_axi_arready;
	assign wrReg         = decodeReg(awAddr_q);
	assign rdReg         = decodeReg(s_axi_araddr);
	assign wrByte        = wByte_q;

	// Write channel latches and response
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			awHeld_q     <= 1'b0;
			wHeld_q      <= 1'b0;
			awAddr_q     <= 8'h00;
			wByte_q      <= 8'h00;
			wLane0_q     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q  <= 1'b1;
				wByte_q  <= s_axi_wdata[7:0];
				wLane0_q <= s_axi_wstrb[0];
			end
			// Both halves present: perform the write and answer
			if (doWrite)
			begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wrReg == REG_NONE) ? `SC_RESP_SLVERR : `SC_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read data multiplexer
	always_comb
	begin
		case (rdReg)
			REG_SEL:  rdByte = {4'h0, selField_q, bypass_q, 1'b0};
			REG_PROT: rdByte = prot_q;
			REG_IRQ:  rdByte = {lenDone_q, 2'h0, rxCnt_q != 2'h0, 4'h0};
			REG_IEN:  rdByte = ien_q;
			REG_ICTL: rdByte = {2'h0, sampleIo_q[0], ctl_q[0]};
			REG_ECTL: rdByte = {2'h0, sampleIo_q[1], ctl_q[1]};
			REG_TXC:  rdByte = {direct_q, 5'h00, txCnt_q};
			REG_TXD:  rdByte = txMem[txRp_q];
			REG_RXC:  rdByte = {rxMem[rxRp_q][8], 5'h00, rxCnt_q == 2'h2, rxCnt_q != 2'h0};
			REG_RXD:  rdByte = rxMem[rxRp_q][7:0];
			REG_ETU:  rdByte = etuDiv_q;
			REG_RLEN: rdByte = lenCnt_q;
			REG_ICLK: rdByte = clkDiv_q[0];
			REG_ECLK: rdByte = clkDiv_q[1];
			default:  rdByte = 8'h00;
		endcase
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SC_RESP_OKAY;
		end
		else if (rdGo)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= (rdReg == REG_NONE) ? `SC_RESP_SLVERR : `SC_RESP_OKAY;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software written configuration
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			selField_q <= 2'h0;
			bypass_q   <= 1'b0;
			prot_q     <= 8'h00;
			ien_q      <= 8'h00;
			direct_q   <= 1'b0;
			etuDiv_q   <= `SC_ETU_RST;
			ctl_q[0]   <= '0;
			ctl_q[1]   <= '0;
			clkDiv_q[0] <= `SC_CLKDIV_RST;
			clkDiv_q[1] <= `SC_CLKDIV_RST;
		end
		else if (doWrite && wLane0_q)
		begin
			case (wrReg)
				REG_SEL:
				begin
					selField_q <= wrByte[3:2];
					bypass_q   <= wrByte[`SC_SEL_BYPASS];
				end
				REG_PROT: prot_q      <= wrByte;
				REG_IEN:  ien_q       <= wrByte;
				REG_ICTL: ctl_q[0]    <= wrByte[4:0];
				REG_ECTL: ctl_q[1]    <= wrByte[4:0];
				REG_TXC:  direct_q    <= wrByte[`SC_TXC_DIRECT];
				REG_ETU:  etuDiv_q    <= wrByte;
				REG_ICLK: clkDiv_q[0] <= wrByte;
				REG_ECLK: clkDiv_q[1] <= wrByte;
				default:  ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Synchronous clock engine driven by the ETU counter
	always_ff @(posedge clock)
	begin
		if (sys_rst || !syncOn)
		begin
			etuCnt_q   <= 8'h00;
			sclk_q     <= 1'b0;
			clkState_q <= CLK_RUN;
			skip_q     <= 1'b0;
		end
		else
		begin
			etuCnt_q <= etuTick ? 8'h00 : etuCnt_q + 8'h01;
			if (fallEv)
				skip_q <= 1'b0;
			case (clkState_q)
				CLK_RUN:
				begin
					// Phase ends; stop only once the stop level is reached
					if (etuTick && ctl_q[selIdx].halt && sclk_q == ctl_q[selIdx].stopLevel)
						clkState_q <= CLK_STOPPED;
					else if (etuTick)
						sclk_q <= !sclk_q;
				end
				CLK_STOPPED:
				begin
					if (haltFall)
					begin
						clkState_q <= CLK_RUN;
						etuCnt_q   <= 8'h00;
						if (sclk_q)
						begin
							sclk_q <= 1'b0;
							skip_q <= lenMax_q != 8'h00 && lenCnt_q == 8'h00;
						end
					end
				end
				default: clkState_q <= CLK_RUN;
			endcase
		end
	end

	// Edge detection history
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sclkPrev_q   <= 1'b0;
			haltPrev_q   <= 1'b0;
			txModePrev_q <= 1'b0;
		end
		else
		begin
			sclkPrev_q   <= sclk_q;
			haltPrev_q   <= ctl_q[selIdx].halt;
			txModePrev_q <= ctl_q[selIdx].txMode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Length counter and its flags
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			lenMax_q  <= 8'h00;
			lenCnt_q  <= 8'h00;
			lenDone_q <= 1'b0;
		end
		else
		begin
			if (doWrite && wLane0_q && wrReg == REG_RLEN)
			begin
				lenMax_q <= wrByte;
				lenCnt_q <= 8'h00;
			end
			else if (fallEv && syncOn && !atEnd)
				lenCnt_q <= lenCnt_q + 8'h01;
			// Set wins over clear-on-read
			if (fallEv && syncOn && !atEnd && lenCnt_q + 8'h01 == lenMax_q)
				lenDone_q <= 1'b1;
			else if (rdGo && rdReg == REG_IRQ)
				lenDone_q <= 1'b0;
		end
	end
	assign lengthIrq = (lenDone_q && ien_q[`SC_IRQ_LEN]) ||
	                   (rxCnt_q != 2'h0 && ien_q[`SC_IRQ_RXAV]);

	////////////////////////////////////////////////////////////////////////////////
	// Transmit FIFO, two bytes
	always_ff @(posedge clock)
	begin
		if (doWrite && wLane0_q && wrReg == REG_TXD && txCnt_q != 2'h2)
			txMem[txWp_q] <= wrByte;
	end

	// Transmit pointers and double read reset
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			txWp_q       <= 1'b0;
			txRp_q       <= 1'b0;
			txCnt_q      <= 2'h0;
			lastTxRead_q <= 1'b0;
		end
		else
		begin
			if (rdGo)
				lastTxRead_q <= rdReg == REG_TXD && !lastTxRead_q;
			else if (doWrite)
				lastTxRead_q <= 1'b0;
			if (rdGo && rdReg == REG_TXD && lastTxRead_q)
			begin
				txWp_q  <= txRp_q;
				txCnt_q <= 2'h0;
			end
			else
			begin
				if (doWrite && wLane0_q && wrReg == REG_TXD && txCnt_q != 2'h2)
					txWp_q <= !txWp_q;
				if (fifoFall && bitPtr_q == 4'h7 && txCnt_q != 2'h0)
					txRp_q <= !txRp_q;
				txCnt_q <= txCnt_q
					+ ((doWrite && wLane0_q && wrReg == REG_TXD && txCnt_q != 2'h2) ? 2'h1 : 2'h0)
					- ((fifoFall && bitPtr_q == 4'h7 && txCnt_q != 2'h0) ? 2'h1 : 2'h0);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serializer and deserializer
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			bitPtr_q  <= 4'h0;
			ioBit_q   <= 1'b1;
			rxShift_q <= 9'h000;
		end
		else if (ctl_q[selIdx].txMode != txModePrev_q)
			bitPtr_q <= 4'h0;
		else if (fifoFall)
		begin
			ioBit_q  <= (txCnt_q != 2'h0) ? txMem[txRp_q][bitPtr_q[2:0]] : 1'b1;
			bitPtr_q <= (bitPtr_q == 4'h7) ? 4'h0 : bitPtr_q + 4'h1;
		end
		else if (rxRise)
		begin
			rxShift_q[bitPtr_q] <= ioIn[selIdx];
			if (bitPtr_q == (prot_q[`SC_PROT_NINE] ? 4'h8 : 4'h7))
				bitPtr_q <= 4'h0;
			else
				bitPtr_q <= bitPtr_q + 4'h1;
		end
	end

	// Receive FIFO, two words of up to nine bits
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			rxWp_q  <= 1'b0;
			rxRp_q  <= 1'b0;
			rxCnt_q <= 2'h0;
		end
		else
		begin
			if (rxRise && bitPtr_q == (prot_q[`SC_PROT_NINE] ? 4'h8 : 4'h7) && rxCnt_q != 2'h2)
			begin
				rxMem[rxWp_q] <= prot_q[`SC_PROT_NINE] ? {ioIn[selIdx], rxShift_q[7:0]}
					: {1'b0, ioIn[selIdx], rxShift_q[6:0]};
				rxWp_q <= !rxWp_q;
			end
			if (rdGo && rdReg == REG_RXD && rxCnt_q != 2'h0)
				rxRp_q <= !rxRp_q;
			rxCnt_q <= rxCnt_q
				+ ((rxRise && bitPtr_q == (prot_q[`SC_PROT_NINE] ? 4'h8 : 4'h7)
					&& rxCnt_q != 2'h2) ? 2'h1 : 2'h0)
				- ((rdGo && rdReg == REG_RXD && rxCnt_q != 2'h0) ? 2'h1 : 2'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per interface dividers, I/O sampling and pin drive
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : gIf
			// Asynchronous card clock divider
			always_ff @(posedge clock)
			begin
				if (sys_rst)
				begin
					freeCnt_q[i] <= 8'h00;
					freeClk_q[i] <= 1'b0;
				end
				else if (freeCnt_q[i] == clkDiv_q[i])
				begin
					freeCnt_q[i] <= 8'h00;
					freeClk_q[i] <= !freeClk_q[i];
				end
				else
					freeCnt_q[i] <= freeCnt_q[i] + 8'h01;
			end
			// Sampled I/O level: on clock rise in sync mode, else followed
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					sampleIo_q[i] <= 1'b1;
				else if (!(syncOn && selIdx == i) || riseEv)
					sampleIo_q[i] <= ioIn[i];
			end
			// Pin drive
			always_comb
			begin
				if (syncOn && selIdx == i)
					pins[i].clk = sclk_q;
				else if (prot_q[i ? `SC_PROT_ESYNC : `SC_PROT_ISYNC])
					pins[i].clk = 1'b0;
				else if (ctl_q[i].halt)
					pins[i].clk = ctl_q[i].stopLevel;
				else
					pins[i].clk = freeClk_q[i];
				if (syncOn && selIdx == i && !regCtl)
				begin
					pins[i].ioOut = ioBit_q;
					pins[i].ioOe  = ctl_q[i].txMode;
				end
				else
				begin
					pins[i].ioOut = ctl_q[i].ioData;
					pins[i].ioOe  = ctl_q[i].ioDir;
				end
			end
		end
	endgenerate
	assign intCard = pins[0];
	assign extCard = pins[1];
endmodule

// ### src/sc_sync_map.svh
// Register offsets, field positions, reset values and response codes of the synchronous card block
`ifndef SC_SYNC_MAP_SVH
`define SC_SYNC_MAP_SVH
`define SC_OFF_SEL   8'h00
`define SC_OFF_PROT  8'h04
`define SC_OFF_IRQ   8'h08
`define SC_OFF_IEN   8'h0C
`define SC_OFF_ICTL  8'h10
`define SC_OFF_ECTL  8'h14
`define SC_OFF_TXC   8'h18
`define SC_OFF_TXD   8'h1C
`define SC_OFF_RXC   8'h20
`define SC_OFF_RXD   8'h24
`define SC_OFF_ETU   8'h28
`define SC_OFF_RLEN  8'h2C
`define SC_OFF_ICLK  8'h30
`define SC_OFF_ECLK  8'h34
`define SC_SEL_BYPASS  1
`define SC_PROT_ISYNC  7
`define SC_PROT_NINE   6
`define SC_PROT_ESYNC  5
`define SC_IRQ_LEN     7
`define SC_IRQ_RXAV    4
`define SC_TXC_DIRECT  7
`define SC_ETU_RST     8'h0F
`define SC_CLKDIV_RST  8'h03
`define SC_RESP_OKAY   2'h0
`define SC_RESP_SLVERR 2'h2
`endif

// ### src/sc_sync_pkg.sv
// Types shared by the synchronous card block
package sc_sync_pkg;
	// Pins of one card interface
	typedef struct packed {
		logic clk;   // Card clock
		logic ioOut; // Card I/O level when driven
		logic ioOe;  // High while the I/O pin is driven
	} card_pins_s;
	// Software control of one card interface, bit 4 down to bit 0
	typedef struct packed {
		logic stopLevel; // Clock stop level
		logic halt;      // Clock halt request
		logic txMode;    // 1 transmit, 0 receive
		logic ioDir;     // 1 drives the I/O pin
		logic ioData;    // Level driven under register control
	} card_ctl_s;
	// Register decode
	typedef enum {REG_SEL, REG_PROT, REG_IRQ, REG_IEN, REG_ICTL, REG_ECTL, REG_TXC, REG_TXD,
		REG_RXC, REG_RXD, REG_ETU, REG_RLEN, REG_ICLK, REG_ECLK, REG_NONE} reg_e;
	// Synchronous clock engine
	typedef enum {CLK_RUN, CLK_STOPPED} clk_state_e;
endpackage

// ### sim/smart_card_sync_props.sv
// Concurrent checks on the ports of the synchronous card block
`timescale 1ns/1ps
module smart_card_sync_props
	import sc_sync_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire sc_sync_pkg::card_pins_s intCard,
	input wire sc_sync_pkg::card_pins_s extCard,
	input wire logic        lengthIrq
);
	default clocking cb @(posedge clock);
	endclocking
	// Read address taken, then registered answer with an empty upper part
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_answer;
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endsequence
	a_rd_answer: assert property (disable iff (sys_rst) s_rd_taken |=> s_rd_answer)
		else $error("read not answered next cycle");
	a_rv_cause: assert property (disable iff (sys_rst)
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
	a_rv_hold: assert property (disable iff (sys_rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_bv_hold: assert property (disable iff (sys_rst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	a_aw_block: assert property (disable iff (sys_rst) s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while answer pending");
	a_ar_block: assert property (disable iff (sys_rst) s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_resp_legal: assert property (disable iff (sys_rst)
		s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("illegal write response code");
	a_rst_quiet: assert property (sys_rst |=> !intCard.clk && !extCard.clk && !intCard.ioOe
		&& !extCard.ioOe && !lengthIrq && !s_axi_rvalid && !s_axi_bvalid)
		else $error("outputs active after reset");
endmodule
bind smart_card_sync smart_card_sync_props chk (.clock, .sys_rst, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .intCard, .extCard, .lengthIrq);

// ### sim/sync_card_model.sv
// Behavioural synchronous card on the far side of one card interface
`timescale 1ns/1ps
module sync_card_model (
	input  wire logic       cardClk,
	input  wire logic       devOe,
	input  wire logic       devOut,
	input  wire logic       talk,
	input  wire logic [7:0] sendByte,
	output logic            ioLine,
	output logic [7:0]      gotByte
);
	int idx = 0;
	// Released line is pulled up; card bits go out LSB first
	assign ioLine = devOe ? devOut : (talk ? sendByte[idx[2:0]] : 1'b1);
	// A new answer starts from bit 0
	always @(posedge talk)
		idx = 0;
	// Card changes its bit on the clock fall
	always @(negedge cardClk)
		if (talk)
			idx = idx + 1;
	// Card samples driven bits on the clock rise
	initial gotByte = 8'h00;
	always @(posedge cardClk)
		if (devOe)
			gotByte = {ioLine, gotByte[7:1]};
endmodule

// ### sim/smart_card_sync_tb_top.sv
// Self-checking bench of the synchronous card block
`timescale 1ns/1ps
module smart_card_sync_tb_top;
	import sc_sync_pkg::*;
	logic        clock, sys_rst, talk, intIoIn, extIoIn, lengthIrq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, sendByte, gotByte;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	card_pins_s  intCard, extCard;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          extEdges = 0;

	smart_card_sync dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .intCard, .intIoIn, .extCard, .extIoIn, .lengthIrq);
	sync_card_model card (.cardClk(intCard.clk), .devOe(intCard.ioOe), .devOut(intCard.ioOut),
		.talk, .sendByte, .ioLine(intIoIn), .gotByte);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge extCard.clk)
		extEdges++;
	// Hang guard
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("Errors %0d of %0d checks", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Write one register; ready is judged at the falling edge before the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, b;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clock);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge clock);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clock);
			ar = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge clock);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	task automatic pins(input logic [1:0] e);
		@(negedge clock);
		chk({intCard.ioOe, intCard.ioOut}, e);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (lengthIrq !== 1'b1 && n < 400)
		begin
			@(posedge clock);
			n++;
		end
		chk(lengthIrq, 1'b1);
	endtask

	task automatic t_reset;
		logic [7:0] d;
		logic [1:0] r;
		rdc(8'h04, 8'h00);
		rdc(8'h2C, 8'h00);
		rdc(8'h18, 8'h00);
		rdc(8'h28, 8'h0F);
		rd(8'hFC, d, r);
		chk(r, 2'h2);
	endtask
	// Overfill, then two reads in a row restart the write pointer
	task automatic t_fifo;
		wr(8'h1C, 8'h11);
		wr(8'h1C, 8'h22);
		wr(8'h1C, 8'h33);
		rdc(8'h18, 8'h02);
		rdc(8'h1C, 8'h11);
		rdc(8'h1C, 8'h11);
		rdc(8'h18, 8'h00);
		wr(8'h1C, 8'h44);
		rdc(8'h1C, 8'h44);
		rdc(8'h1C, 8'h44);
	endtask
	task automatic t_bypass;
		wr(8'h00, 8'h0A);
		wr(8'h10, 8'h03);
		pins(2'b11);
		wr(8'h10, 8'h02);
		pins(2'b10);
		wr(8'h10, 8'h00);
		pins(2'b00);
		rdc(8'h10, 8'h20);
	endtask
	// Byte out through the counter, then direct and zero-length control
	task automatic t_tx;
		int e0;
		wr(8'h00, 8'h0C);
		wr(8'h28, 8'h01);
		wr(8'h04, 8'hA0);
		wr(8'h10, 8'h0C);
		e0 = extEdges;
		wr(8'h1C, 8'hA5);
		wr(8'h0C, 8'h80);
		wr(8'h2C, 8'h08);
		wr(8'h10, 8'h04);
		wait_irq;
		// The first rise only sees the idle level; the ninth rise completes the byte
		@(posedge intCard.clk);
		@(negedge clock);
		chk(gotByte, 8'hA5);
		rdc(8'h08, 8'h80);
		rdc(8'h08, 8'h00);
		rdc(8'h2C, 8'h08);
		chk(extEdges - e0, 0);
		wr(8'h18, 8'h80);
		wr(8'h10, 8'h06);
		pins(2'b10);
		wr(8'h10, 8'h07);
		pins(2'b11);
		wr(8'h18, 8'h00);
		wr(8'h2C, 8'h00);
		wr(8'h10, 8'h02);
		pins(2'b10);
	endtask
	// Stop high with a byte queued, then restart: the first fall must not launch bit 0
	task automatic t_halt;
		wr(8'h28, 8'h0F);
		wr(8'h10, 8'h1C);
		wr(8'h1C, 8'hFE);
		repeat (40) @(posedge clock);
		chk(intCard.clk, 1'b1);
		// A running clock would show the other level one half period later
		repeat (16) @(posedge clock);
		chk(intCard.clk, 1'b1);
		wr(8'h2C, 8'h01);
		wr(8'h10, 8'h04);
		@(negedge clock);
		chk(intCard.clk, 1'b0);
		pins(2'b11);
	endtask
	// Nine-bit answer from the card after a restart from a low stop
	task automatic t_rx;
		logic [7:0] d;
		logic [1:0] r;
		wr(8'h28, 8'h01);
		wr(8'h10, 8'h08);
		wr(8'h04, 8'hC0);
		rd(8'h08, d, r);
		sendByte <= 8'h3D;
		talk <= 1'b1;
		wr(8'h2C, 8'h09);
		wr(8'h10, 8'h00);
		wait_irq;
		rdc(8'h20, 8'h81);
		rdc(8'h24, 8'h3D);
		talk <= 1'b0;
	endtask

	initial
	begin
		sys_rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		extIoIn = 1'b1;
		talk = 1'b0;
		sendByte = 8'h00;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset;
		t_fifo;
		t_bypass;
		t_tx;
		t_halt;
		t_rx;
		end_sim;
	end
endmodule
